// ===== include/flk_pkg.sv
// shared constants for the flash lock and protection-register host controller
package flk_pkg;
   // clock and pin timing
   localparam int CLK_NS      = 8;
   localparam int T_WP_NS     = 70;   // least write-enable low time
   localparam int T_WPH_NS    = 30;   // least write-enable high time
   localparam int T_ACC_NS    = 70;   // read access time
   localparam int T_WP_CYC    = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_WPH_CYC   = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_ACC_CYC   = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int SYNC_LAT    = 3;    // input synchroniser depth
   localparam int RD_WAIT_CYC = T_ACC_CYC + SYNC_LAT;

   // widths
   localparam int FA_W = 22;
   localparam int DQ_W = 16;

   // flash command codes
   localparam logic [15:0] CMD_LOCK_SETUP   = 16'h0060;
   localparam logic [15:0] CMD_LOCK_CFM     = 16'h0001;
   localparam logic [15:0] CMD_UNLOCK_CFM   = 16'h00D0;
   localparam logic [15:0] CMD_LOCKDOWN_CFM = 16'h002F;
   localparam logic [15:0] CMD_READ_ID      = 16'h0090;
   localparam logic [15:0] CMD_READ_ARRAY   = 16'h00FF;
   localparam logic [15:0] CMD_READ_STATUS  = 16'h0070;
   localparam logic [15:0] CMD_CLEAR_STATUS = 16'h0050;
   localparam logic [15:0] CMD_PROT_SETUP   = 16'h00C0;
   localparam logic [15:0] CMD_SUSPEND      = 16'h00B0;
   localparam logic [15:0] CMD_RESUME       = 16'h00D0;
   localparam logic [15:0] OTP_LOCK_DATA    = 16'hFFFD;

   // device map
   localparam logic [21:0] LOCK_STATE_OFS = 22'h000002;  // block_lock_state word offset
   localparam logic [21:0] PROT_FIRST     = 22'h000080;
   localparam logic [21:0] PROT_LAST      = 22'h000088;
   localparam logic [21:0] OTP_LOCK_ADDR  = 22'h000080;  // otp_lock_word address

   // device status and lock-state bit positions
   localparam int LOCK_ERROR_FLAG    = 1;
   localparam int SUPPLY_ERROR_FLAG  = 3;
   localparam int PROGRAM_ERROR_FLAG = 4;
   localparam int ERASE_ERROR_FLAG   = 5;
   localparam int ERASE_SUSP_FLAG    = 6;
   localparam int MACHINE_READY_FLAG = 7;
   localparam int LOCK_BIT_LINE      = 0;
   localparam int LOCKDOWN_BIT_LINE  = 1;

   // avalon register word indexes
   localparam logic [2:0] REG_CMD    = 3'h0;
   localparam logic [2:0] REG_ADDR   = 3'h1;
   localparam logic [2:0] REG_WDATA  = 3'h2;
   localparam logic [2:0] REG_PINS   = 3'h3;
   localparam logic [2:0] REG_STATUS = 3'h4;
   localparam logic [2:0] REG_RESULT = 3'h5;

   // register fields and reset values
   localparam int ST_BUSY    = 0;
   localparam int ST_REFUSED = 1;
   localparam int ST_SEQERR  = 2;
   localparam int ST_DEV_LSB = 8;
   localparam int PIN_WP     = 0;
   localparam int PIN_RST_N  = 1;
   localparam logic [1:0] PINS_RESET = 2'h2;

   // host operations
   localparam logic [3:0] OP_NONE      = 4'h0;
   localparam logic [3:0] OP_LOCK      = 4'h1;
   localparam logic [3:0] OP_UNLOCK    = 4'h2;
   localparam logic [3:0] OP_LOCKDOWN  = 4'h3;
   localparam logic [3:0] OP_READ_LOCK = 4'h4;
   localparam logic [3:0] OP_READ_PROT = 4'h5;
   localparam logic [3:0] OP_PROT_PROG = 4'h6;
   localparam logic [3:0] OP_OTP_LOCK  = 4'h7;
   localparam logic [3:0] OP_SUSPEND   = 4'h8;
   localparam logic [3:0] OP_RESUME    = 4'h9;
   localparam logic [3:0] OP_RD_STATUS = 4'hA;
   localparam logic [3:0] OP_CLR_STAT  = 4'hB;

   typedef enum logic [1:0] {K_END, K_WR, K_RD, K_POLL} flk_kind_t;
endpackage : flk_pkg

// ===== core/flk_sync.sv
// three-stage input synchroniser, value taken once stages two and three agree
module flk_sync #(
   parameter int W = 16
) (
   // system
   input  wire logic         sys_clk,
   input  wire logic         rst,
   // pins and result
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] pin_out
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] out_r;

   // per bit: first stage feeds only the second
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            s1_r[i]  <= 1'b0;
            s2_r[i]  <= 1'b0;
            s3_r[i]  <= 1'b0;
            out_r[i] <= 1'b0;
         end else begin
            s1_r[i] <= pin_in[i];
            s2_r[i] <= s1_r[i];
            s3_r[i] <= s2_r[i];
            if (s2_r[i] == s3_r[i]) begin
               out_r[i] <= s3_r[i];
            end
         end
      end
   end

   assign pin_out = out_r;
endmodule : flk_sync

// ===== core/flk_host.sv
// host controller driving a parallel flash for block locking and protection register access
//
// Local design decision: register access over Avalon-MM.
module flk_host (
   // system
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // avalon-mm slave
   input  wire logic [2:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // flash pins
   output logic      [21:0] flash_addr,
   output logic      [15:0] flash_dq_out,
   output logic             flash_dq_oe_n,
   input  wire logic [15:0] flash_dq_in,
   output logic             flash_ce_n,
   output logic             flash_oe_n,
   output logic             flash_we_n,
   output logic             flash_wp_n,
   output logic             flash_rst_n
);
   typedef enum logic [2:0] {S_IDLE, S_STEP, S_WR_SET, S_WR_PULSE, S_WR_HOLD, S_RD} flk_state_t;

   flk_state_t        state_r;
   flk_pkg::flk_kind_t seq_kind;
   logic [21:0] seq_addr;
   logic [15:0] seq_data;
   logic [3:0]  op_r;
   logic [2:0]  step_r;
   logic [4:0]  cnt_r;
   logic [21:0] addr_r;
   logic [15:0] wdata_r;
   logic [1:0]  pins_r;
   logic [7:0]  stat_r;
   logic [15:0] result_r;
   logic        refused_r;
   logic        wait_r;
   logic [31:0] rdata_r;
   logic [21:0] fa_r;
   logic [15:0] dq_r;
   logic        dq_oe_n_r;
   logic        ce_n_r;
   logic        oe_n_r;
   logic        we_n_r;
   logic [15:0] dq_sync;
   logic [15:0] prev_wr_r;
   logic        acc_wr;
   logic        start_req;
   logic        prot_out;
   logic        refuse;
   logic        seq_err;

   flk_sync #(.W(flk_pkg::DQ_W)) u_dq_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pin_in  (flash_dq_in),
      .pin_out (dq_sync)
   );

   // request decode; a command needs one wait cycle before it is taken
   assign acc_wr    = avs_write && !wait_r;
   assign start_req = acc_wr && (avs_address == flk_pkg::REG_CMD);
   assign prot_out  = (addr_r < flk_pkg::PROT_FIRST) || (addr_r > flk_pkg::PROT_LAST);
   assign refuse    = (state_r != S_IDLE) ||
                      ((avs_writedata[3:0] == flk_pkg::OP_PROT_PROG) && prot_out);
   assign seq_err   = stat_r[flk_pkg::PROGRAM_ERROR_FLAG] && stat_r[flk_pkg::ERASE_ERROR_FLAG] &&
                      stat_r[flk_pkg::MACHINE_READY_FLAG];

   // bus-cycle program of each operation
   always_comb begin
      seq_kind = flk_pkg::K_END;
      seq_addr = addr_r;
      seq_data = 16'h0000;
      case (op_r)
         flk_pkg::OP_LOCK, flk_pkg::OP_UNLOCK, flk_pkg::OP_LOCKDOWN: begin
            case (step_r)
               3'h0: begin
                  seq_kind = flk_pkg::K_WR;
                  seq_data = flk_pkg::CMD_LOCK_SETUP;
               end
               3'h1: begin
                  seq_kind = flk_pkg::K_WR;
                  seq_data = (op_r == flk_pkg::OP_LOCK)   ? flk_pkg::CMD_LOCK_CFM :
                             (op_r == flk_pkg::OP_UNLOCK) ? flk_pkg::CMD_UNLOCK_CFM :
                                                            flk_pkg::CMD_LOCKDOWN_CFM;
               end
               3'h2: begin
                  seq_kind = flk_pkg::K_WR;
                  seq_data = flk_pkg::CMD_READ_STATUS;
               end
               3'h3: seq_kind = flk_pkg::K_POLL;
               default: seq_kind = flk_pkg::K_END;
            endcase
         end
         flk_pkg::OP_READ_LOCK, flk_pkg::OP_READ_PROT: begin
            case (step_r)
               3'h0: begin
                  seq_kind = flk_pkg::K_WR;
                  seq_data = flk_pkg::CMD_READ_ID;
               end
               3'h1: begin
                  seq_kind = flk_pkg::K_RD;
                  if (op_r == flk_pkg::OP_READ_LOCK) begin
                     seq_addr = addr_r + flk_pkg::LOCK_STATE_OFS;
                  end
               end
               3'h2: begin
                  seq_kind = flk_pkg::K_WR;
                  seq_data = flk_pkg::CMD_READ_ARRAY;
               end
               default: seq_kind = flk_pkg::K_END;
            endcase
         end
         flk_pkg::OP_PROT_PROG, flk_pkg::OP_OTP_LOCK: begin
            if (op_r == flk_pkg::OP_OTP_LOCK) begin
               seq_addr = flk_pkg::OTP_LOCK_ADDR;
            end
            case (step_r)
               3'h0: begin
                  seq_kind = flk_pkg::K_WR;
                  seq_data = flk_pkg::CMD_PROT_SETUP;
               end
               3'h1: begin
                  seq_kind = flk_pkg::K_WR;
                  seq_data = (op_r == flk_pkg::OP_OTP_LOCK) ? flk_pkg::OTP_LOCK_DATA : wdata_r;
               end
               3'h2: seq_kind = flk_pkg::K_POLL;
               default: seq_kind = flk_pkg::K_END;
            endcase
         end
         flk_pkg::OP_SUSPEND, flk_pkg::OP_RD_STATUS: begin
            case (step_r)
               3'h0: begin
                  seq_kind = flk_pkg::K_WR;
                  seq_data = (op_r == flk_pkg::OP_SUSPEND) ? flk_pkg::CMD_SUSPEND : flk_pkg::CMD_READ_STATUS;
               end
               3'h1: begin
                  seq_kind = flk_pkg::K_WR;
                  seq_data = flk_pkg::CMD_READ_STATUS;
               end
               3'h2: seq_kind = flk_pkg::K_POLL;
               default: seq_kind = flk_pkg::K_END;
            endcase
         end
         flk_pkg::OP_RESUME, flk_pkg::OP_CLR_STAT: begin
            if (step_r == 3'h0) begin
               seq_kind = flk_pkg::K_WR;
               seq_data = (op_r == flk_pkg::OP_RESUME) ? flk_pkg::CMD_RESUME : flk_pkg::CMD_CLEAR_STATUS;
            end
         end
         default: seq_kind = flk_pkg::K_END;
      endcase
   end

   // sequencer and flash pin drive; dq is released before oe ever falls
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_r   <= S_IDLE;
         op_r      <= flk_pkg::OP_NONE;
         step_r    <= 3'h0;
         cnt_r     <= 5'h00;
         fa_r      <= 22'h000000;
         dq_r      <= 16'h0000;
         dq_oe_n_r <= 1'b1;
         ce_n_r    <= 1'b1;
         oe_n_r    <= 1'b1;
         we_n_r    <= 1'b1;
         prev_wr_r <= 16'h0000;
         stat_r    <= 8'h00;
         result_r  <= 16'h0000;
      end else begin
         case (state_r)
            S_IDLE: begin
               if (start_req && !refuse) begin
                  op_r    <= avs_writedata[3:0];
                  step_r  <= 3'h0;
                  state_r <= S_STEP;
               end
            end
            S_STEP: begin
               cnt_r <= 5'h00;
               fa_r  <= seq_addr;
               case (seq_kind)
                  flk_pkg::K_WR: begin
                     dq_r      <= seq_data;
                     dq_oe_n_r <= 1'b0;
                     ce_n_r    <= 1'b0;
                     state_r   <= S_WR_SET;
                  end
                  flk_pkg::K_RD, flk_pkg::K_POLL: begin
                     ce_n_r  <= 1'b0;
                     oe_n_r  <= 1'b0;
                     state_r <= S_RD;
                  end
                  default: state_r <= S_IDLE;
               endcase
            end
            S_WR_SET: begin
               we_n_r  <= 1'b0;
               state_r <= S_WR_PULSE;
            end
            S_WR_PULSE: begin
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r == 5'(flk_pkg::T_WP_CYC - 1)) begin
                  we_n_r  <= 1'b1;
                  cnt_r   <= 5'h00;
                  state_r <= S_WR_HOLD;
               end
            end
            S_WR_HOLD: begin
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r == 5'(flk_pkg::T_WPH_CYC - 1)) begin
                  ce_n_r    <= 1'b1;
                  dq_oe_n_r <= 1'b1;
                  prev_wr_r <= dq_r;
                  step_r    <= step_r + 3'h1;
                  state_r   <= S_STEP;
               end
            end
            S_RD: begin
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r == 5'(flk_pkg::RD_WAIT_CYC - 1)) begin
                  ce_n_r  <= 1'b1;
                  oe_n_r  <= 1'b1;
                  state_r <= S_STEP;
                  if (seq_kind == flk_pkg::K_POLL) begin
                     stat_r <= dq_sync[7:0];
                     // busy device: read status again at the same step
                     if (dq_sync[flk_pkg::MACHINE_READY_FLAG]) begin
                        step_r <= step_r + 3'h1;
                     end
                  end else begin
                     result_r <= dq_sync;
                     step_r   <= step_r + 3'h1;
                  end
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // software registers; hardware refusal wins over a clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         addr_r    <= 22'h000000;
         wdata_r   <= 16'h0000;
         pins_r    <= flk_pkg::PINS_RESET;
         refused_r <= 1'b0;
      end else begin
         if (acc_wr && avs_address == flk_pkg::REG_ADDR) begin
            addr_r <= avs_writedata[21:0];
         end
         if (acc_wr && avs_address == flk_pkg::REG_WDATA) begin
            wdata_r <= avs_writedata[15:0];
         end
         if (acc_wr && avs_address == flk_pkg::REG_PINS) begin
            pins_r <= avs_writedata[1:0];
         end
         if (start_req && refuse) begin
            refused_r <= 1'b1;
         end else if (acc_wr && avs_address == flk_pkg::REG_STATUS && avs_writedata[flk_pkg::ST_REFUSED]) begin
            refused_r <= 1'b0;
         end
      end
   end

   // avalon answer: one wait cycle, then data and release of waitrequest together
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h00000000;
      end else if ((avs_read || avs_write) && wait_r) begin
         wait_r <= 1'b0;
         case (avs_address)
            flk_pkg::REG_ADDR:   rdata_r <= {10'h000, addr_r};
            flk_pkg::REG_WDATA:  rdata_r <= {16'h0000, wdata_r};
            flk_pkg::REG_PINS:   rdata_r <= {30'h00000000, pins_r};
            flk_pkg::REG_STATUS: rdata_r <= {16'h0000, stat_r, 5'h00, seq_err, refused_r, state_r != S_IDLE};
            flk_pkg::REG_RESULT: rdata_r <= {16'h0000, result_r};
            default:             rdata_r <= 32'h00000000;
         endcase
      end else begin
         wait_r <= 1'b1;
      end
   end

   assign avs_readdata    = rdata_r;
   assign avs_waitrequest = wait_r;
   assign flash_addr      = fa_r;
   assign flash_dq_out    = dq_r;
   assign flash_dq_oe_n   = dq_oe_n_r;
   assign flash_ce_n      = ce_n_r;
   assign flash_oe_n      = oe_n_r;
   assign flash_we_n      = we_n_r;
   assign flash_wp_n      = pins_r[flk_pkg::PIN_WP];
   assign flash_rst_n     = pins_r[flk_pkg::PIN_RST_N];

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   AST_LOCK_PAIR: assert property (state_r == S_WR_SET && op_r == flk_pkg::OP_LOCK && step_r == 3'h1
      |-> dq_r == flk_pkg::CMD_LOCK_CFM && prev_wr_r == flk_pkg::CMD_LOCK_SETUP)
      else $error("lock confirm not preceded by setup");
   AST_UNLOCK_PAIR: assert property (state_r == S_WR_SET && op_r == flk_pkg::OP_UNLOCK && step_r == 3'h1
      |-> dq_r == flk_pkg::CMD_UNLOCK_CFM && prev_wr_r == flk_pkg::CMD_LOCK_SETUP)
      else $error("unlock confirm wrong");
   AST_LOCKDOWN_PAIR: assert property (state_r == S_WR_SET && op_r == flk_pkg::OP_LOCKDOWN && step_r == 3'h1
      |-> dq_r == flk_pkg::CMD_LOCKDOWN_CFM && prev_wr_r == flk_pkg::CMD_LOCK_SETUP)
      else $error("lock-down confirm wrong");
   AST_PROT_SECOND: assert property (state_r == S_WR_SET && op_r == flk_pkg::OP_PROT_PROG && step_r == 3'h1
      |-> prev_wr_r == flk_pkg::CMD_PROT_SETUP && fa_r == addr_r && dq_r == wdata_r)
      else $error("protection data write wrong");
   AST_OTP_WORD: assert property (state_r == S_WR_SET && op_r == flk_pkg::OP_OTP_LOCK && step_r == 3'h1
      |-> dq_r == flk_pkg::OTP_LOCK_DATA && fa_r == flk_pkg::OTP_LOCK_ADDR)
      else $error("otp lock word write wrong");
   AST_ID_EXIT: assert property (state_r == S_STEP && seq_kind == flk_pkg::K_END &&
      (op_r == flk_pkg::OP_READ_LOCK || op_r == flk_pkg::OP_READ_PROT)
      |-> prev_wr_r == flk_pkg::CMD_READ_ARRAY ##1 state_r == S_IDLE)
      else $error("identifier mode not left");
   AST_SUSPEND_POLL: assert property (state_r == S_STEP && seq_kind == flk_pkg::K_END &&
      op_r == flk_pkg::OP_SUSPEND |-> stat_r[flk_pkg::MACHINE_READY_FLAG])
      else $error("suspend finished before ready");
   AST_PROT_RANGE: assert property (state_r == S_IDLE && start_req && prot_out &&
      avs_writedata[3:0] == flk_pkg::OP_PROT_PROG |=> state_r == S_IDLE && refused_r)
      else $error("out-of-range protection program started");
   AST_NO_CONTENTION: assert property (!flash_oe_n |-> flash_dq_oe_n && flash_we_n)
      else $error("output enable with host driving");

   COV_LOCK: cover property (state_r == S_STEP && op_r == flk_pkg::OP_LOCK && seq_kind == flk_pkg::K_END);
   COV_LOCKDOWN: cover property (state_r == S_STEP && op_r == flk_pkg::OP_LOCKDOWN && seq_kind == flk_pkg::K_END);
   COV_READ_LOCK: cover property (state_r == S_STEP && op_r == flk_pkg::OP_READ_LOCK && seq_kind == flk_pkg::K_END);
   COV_REFUSED: cover property (start_req && refuse);
endmodule : flk_host

// ===== bench/flk_flash_model.sv
// behavioural flash: block locks, lock-down, status and protection register
module flk_flash_model (
   // flash pins
   input  wire logic [21:0] addr,
   input  wire logic [15:0] dq,
   output logic      [15:0] dq_drv,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic        wp_n,
   input  wire logic        rst_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0]  lk, ld;
   logic [15:0] prot [9];
   logic [7:0]  sr;
   logic [2:0]  md;
   logic [15:0] rd;
   int          b, p;
   task automatic clr;
      lk = 4'hF;
      ld = 4'h0;
      md = 3'h0;
      sr = 8'h80;
   endtask : clr
   // power-up state; factory half comes pre-locked
   initial begin
      clr();
      prot[0] = 16'hFFFE;
      for (int i = 1; i < 9; i++) prot[i] = (i < 5) ? 16'h5A5A : 16'hFFFF; // arbitrary factory number
   end
   always @(negedge rst_n) clr();
   // dropping write-protect discards unlocks of locked-down blocks
   always @(negedge wp_n) lk = lk | ld;
   // commands taken at the write-enable rising edge
   always @(posedge we_n) if (!ce_n && rst_n) begin
      b = addr[16:15];
      p = int'(addr[7:0]) - 128;
      // lock sequences act at once, even with an erase suspended
      if (md == 3'h3) begin
         md = 3'h1;
         if (dq[7:0] == 8'h2F) {ld[b], lk[b]} = 2'h3;
         else if (dq[7:0] != 8'h01 && dq[7:0] != 8'hD0) sr[5:4] = 2'h3;
         else if (!(ld[b] && !wp_n)) lk[b] = (dq[7:0] == 8'h01);
      end else if (md == 3'h4) begin
         md = 3'h1;
         if (!prot[0][(p > 0 && p < 5) ? 0 : 1]) sr = sr | 8'h12;
         else if (p >= 0 && p < 9) prot[p] = prot[p] & dq;
      end else begin
         case (dq[7:0])
            8'h60: md = 3'h3;
            8'hC0: md = 3'h4;
            8'h90: md = 3'h2;
            8'hFF: md = 3'h0;
            8'h70: md = 3'h1;
            8'h50: sr[5:1] = 5'h0;
            8'hB0: {sr[6], md} = 4'h9;
            8'hD0: sr[6] = 1'b0;
            default: md = md;
         endcase
      end
   end
   // released lines show the inverse, so a stale value never passes
   always @* begin
      if (md != 3'h2) rd = (md == 3'h0) ? ~addr[15:0] : {8'h00, sr};
      else if (addr[14:0] == 15'h0002) rd = {14'h0, ld[addr[16:15]], lk[addr[16:15]]};
      else if (addr[7:0] >= 8'h80 && addr[7:0] <= 8'h88) rd = prot[addr[3:0]];
      else rd = 16'h0000;
      dq_drv = (!ce_n && !oe_n) ? rd : ~rd;
   end
endmodule : flk_flash_model

// ===== bench/flk_host_test.sv
// self-checking bench for the flash lock host controller
module flk_host_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [21:0] B1 = 22'h008000;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic [2:0]  avs_address = 3'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, q;
   logic        avs_waitrequest, dq_oe_n, ce_n, oe_n, we_n, wp_n, f_rst_n;
   logic [21:0] f_addr;
   logic [15:0] dq_out, dq_drv, dq_w;
   int          mismatches = 0;
   int          tests_run = 0;
   // the line follows whichever side has it enabled
   assign dq_w = dq_oe_n ? dq_drv : dq_out;
   always #4 sys_clk = ~sys_clk;
   flk_host dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .flash_addr(f_addr), .flash_dq_out(dq_out), .flash_dq_oe_n(dq_oe_n),
      .flash_dq_in(dq_w), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_wp_n(wp_n),
      .flash_rst_n(f_rst_n));
   flk_flash_model flash (.addr(f_addr), .dq(dq_w), .dq_drv(dq_drv), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .wp_n(wp_n), .rst_n(f_rst_n));
   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one avalon access, held until waitrequest is sampled low
   task automatic av(input logic [2:0] a, input logic w, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address   <= a;
      avs_write     <= w;
      avs_read      <= !w;
      avs_writedata <= d;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : av
   // launch an operation and poll until busy clears; q ends as status
   task automatic op(input logic [3:0] c, input logic [21:0] a, input logic [15:0] d);
      av(flk_pkg::REG_ADDR, 1'b1, {10'h0, a});
      av(flk_pkg::REG_WDATA, 1'b1, {16'h0, d});
      av(flk_pkg::REG_CMD, 1'b1, {28'h0, c});
      do av(flk_pkg::REG_STATUS, 1'b0, 32'h0); while (q[flk_pkg::ST_BUSY] !== 1'b0);
   endtask : op
   task automatic ri(input logic [3:0] c, input logic [21:0] a, input logic [31:0] e);
      op(c, a, 16'h0);
      av(flk_pkg::REG_RESULT, 1'b0, 32'h0);
      chk(q, e);
   endtask : ri
   // watchdog, well beyond the expected run
   initial begin
      #400000;
      mismatches++;
      close_out();
   end
   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      av(flk_pkg::REG_PINS, 1'b0, 32'h0);
      chk(q, {30'h0, flk_pkg::PINS_RESET});
      av(3'h6, 1'b0, 32'h0);
      chk(q, 32'h0);
      ri(flk_pkg::OP_READ_LOCK, B1, 32'h1);
      op(flk_pkg::OP_UNLOCK, B1, 16'h0);
      ri(flk_pkg::OP_READ_LOCK, B1, 32'h0);
      op(flk_pkg::OP_LOCK, B1, 16'h0);
      ri(flk_pkg::OP_READ_LOCK, B1, 32'h1);
      op(flk_pkg::OP_LOCKDOWN, B1, 16'h0);
      ri(flk_pkg::OP_READ_LOCK, B1, 32'h3);
      op(flk_pkg::OP_UNLOCK, B1, 16'h0);
      ri(flk_pkg::OP_READ_LOCK, B1, 32'h3);
      av(flk_pkg::REG_PINS, 1'b1, 32'h3);
      op(flk_pkg::OP_UNLOCK, B1, 16'h0);
      ri(flk_pkg::OP_READ_LOCK, B1, 32'h2);
      av(flk_pkg::REG_PINS, 1'b1, 32'h2);
      ri(flk_pkg::OP_READ_LOCK, B1, 32'h3);
      op(flk_pkg::OP_SUSPEND, 22'h0, 16'h0);
      chk(q & 32'hFF00, 32'hC000);
      // block zero is locked after reset, so this unlock must really land
      op(flk_pkg::OP_UNLOCK, 22'h0, 16'h0);
      ri(flk_pkg::OP_READ_LOCK, 22'h0, 32'h0);
      op(flk_pkg::OP_RESUME, 22'h0, 16'h0);
      ri(flk_pkg::OP_READ_PROT, 22'h85, 32'hFFFF);
      op(flk_pkg::OP_PROT_PROG, 22'h85, 16'h1234);
      av(flk_pkg::REG_WDATA, 1'b0, 32'h0);
      chk(q, 32'h1234);
      ri(flk_pkg::OP_READ_PROT, 22'h85, 32'h1234);
      op(flk_pkg::OP_PROT_PROG, 22'h81, 16'h0);
      chk(q & 32'h1200, 32'h1200);
      op(flk_pkg::OP_CLR_STAT, 22'h0, 16'h0);
      op(flk_pkg::OP_OTP_LOCK, 22'h0, 16'h0);
      ri(flk_pkg::OP_READ_PROT, flk_pkg::OTP_LOCK_ADDR, 32'hFFFC);
      op(flk_pkg::OP_PROT_PROG, 22'h86, 16'h0);
      chk(q & 32'h1200, 32'h1200);
      ri(flk_pkg::OP_READ_PROT, 22'h86, 32'hFFFF);
      op(flk_pkg::OP_PROT_PROG, 22'h90, 16'h0);
      chk(q & 32'h2, 32'h2);
      av(flk_pkg::REG_STATUS, 1'b1, 32'h2);
      av(flk_pkg::REG_STATUS, 1'b0, 32'h0);
      chk(q & 32'h2, 32'h0);
      // last polled byte still holds the errors, so only a fresh poll can show ready alone
      op(flk_pkg::OP_CLR_STAT, 22'h0, 16'h0);
      op(flk_pkg::OP_RD_STATUS, 22'h0, 16'h0);
      chk(q & 32'hFF07, 32'h8000);
      av(flk_pkg::REG_PINS, 1'b1, 32'h0);
      av(flk_pkg::REG_PINS, 1'b1, 32'h2);
      ri(flk_pkg::OP_READ_LOCK, B1, 32'h1);
      // a command while busy is refused; the first one still completes
      av(flk_pkg::REG_CMD, 1'b1, {28'h0, flk_pkg::OP_UNLOCK});
      av(flk_pkg::REG_CMD, 1'b1, {28'h0, flk_pkg::OP_LOCK});
      do av(flk_pkg::REG_STATUS, 1'b0, 32'h0); while (q[flk_pkg::ST_BUSY] !== 1'b0);
      chk(q & 32'h3, 32'h2);
      ri(flk_pkg::OP_READ_LOCK, B1, 32'h0);
      // mid-run reset brings pins and sticky flags back
      av(flk_pkg::REG_PINS, 1'b1, 32'h3);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      av(flk_pkg::REG_PINS, 1'b0, 32'h0);
      chk(q, {30'h0, flk_pkg::PINS_RESET});
      av(flk_pkg::REG_STATUS, 1'b0, 32'h0);
      chk(q, 32'h0);
      close_out();
   end
endmodule : flk_host_test
